// ==== bench/asc_front_model.sv ====
/* asc_front_model: behavioural sample-and-hold and converter front end.
   assumes conv_start pulses on clk; answers delay+1 cycles after the start pulse. */
module asc_front_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       conv_start,
	input  wire logic [7:0] delay,
	input  wire logic [9:0] value,
	output logic            conv_done,
	output logic [9:0]      conv_result
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       busy;
	logic [7:0] count;
	// result holds only in the done cycle; it toggles otherwise so stale reads show
	always_ff @(posedge clk) begin
		conv_done <= 1'b0;
		conv_result <= ~conv_result;
		if (!rst_b) begin
			busy <= 1'b0;
			count <= 8'h00;
			conv_result <= 10'h000;
		end else if (conv_start === 1'b1) begin
			busy <= 1'b1;
			count <= delay;
		end else if (busy && count == 8'h00) begin
			busy <= 1'b0;
			conv_done <= 1'b1;
			conv_result <= value;
		end else if (busy) begin
			count <= count - 8'h01;
		end
	end
endmodule // asc_front_model

// ==== bench/tb.sv ====
/* tb: scenario bench of the converter sequencer.
   assumes asc_pkg, the design and asc_front_model are compiled first. */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0]  c1 = asc_pkg::IDX_CON1;
	localparam logic [4:0]  c2 = asc_pkg::IDX_CON2;
	localparam logic [4:0]  c3 = asc_pkg::IDX_CON3;
	localparam logic [4:0]  bf = asc_pkg::IDX_BUF_BASE;
	localparam logic [31:0] en = 32'h00008000;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        idle_mode = 1'b0;
	logic        rc_osc = 1'b0;
	logic        scan_advance;
	logic        external_irq_pin = 1'b0;
	logic        timer_match = 1'b0;
	logic        charge_done = 1'b0;
	logic        conv_done;
	logic [9:0]  conv_result;
	logic        conversion_clock, sample_hold, conv_start, offset_calibration;
	logic        input_scan_enable, alternate_b_select, buffer_fill_status, conv_irq;
	logic [2:0]  reference_config;
	logic [7:0]  delay = 8'h00;
	logic [9:0]  value = 10'h000;
	logic [31:0] q;
	int          fails = 0;
	int          checks = 0;

	always #5 clk = ~clk;

	asc_sequencer asc_sequencer_i (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
		.idle_mode, .external_irq_pin, .timer_match, .charge_done, .rc_osc,
		.conv_done, .conv_result, .conversion_clock, .sample_hold, .conv_start,
		.reference_config, .offset_calibration, .input_scan_enable, .scan_advance,
		.alternate_b_select, .buffer_fill_status, .conv_irq);
	asc_front_model asc_front_model_i (.clk, .rst_b, .conv_start, .delay, .value,
		.conv_done, .conv_result);

	task automatic summarize();
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// read and write share one cycle; q takes read data at the answer edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			fails++;
			summarize();
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic sig(input int w);
		return (w == 0) ? conv_start : conv_done;
	endfunction

	task automatic await(input int w, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sig(w) !== 1'b1 && n < lim);
		if (sig(w) !== 1'b1) begin
			fails++;
			summarize();
		end
	endtask

	task automatic fire(input logic p);
		external_irq_pin <= p;
		timer_match <= 1'b1;
		charge_done <= 1'b1;
		@(posedge clk);
		timer_match <= 1'b0;
		charge_done <= 1'b0;
	endtask

	function automatic logic [31:0] fmt(input int f, input logic [9:0] r);
		logic [9:0] s;
		s = {~r[9], r[8:0]};
		case (f)
			2: return {16'h0, r, 6'h0};
			3: return {16'h0, s, 6'h0};
			5: return {{22{s[9]}}, s};
			7: return {s, 22'h0};
			default: return {22'h0, r};
		endcase
	endfunction

	task automatic t_regs();
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 5'(i), 32'h0);
			check("reset value", asc_pkg::CON_RESET, q);
		end
		bus(1'b1, c2, 32'hffffffff);
		bus(1'b0, c2, 32'h0);
		check("ctl two", 32'h0000f43f, q);
		check("offset cal", 1, offset_calibration);
		check("scan enable", 1, input_scan_enable);
		bus(1'b1, c3, 32'hffffffff);
		bus(1'b0, c3, 32'h0);
		check("ctl three", 32'h00009fff, q);
		bus(1'b1, 5'h05, 32'hffffffff);
		bus(1'b0, 5'h05, 32'h0);
		check("unmapped", 0, q);
		for (int v = 0; v < 8; v++) begin
			bus(1'b1, c2, 32'(v) << 13);
			repeat (2) @(posedge clk);
			check("reference", 32'(v), 32'(reference_config));
		end
		bus(1'b1, c3, 32'h0);
	endtask

	task automatic t_sw();
		bus(1'b1, c1, 32'h2);
		repeat (2) @(posedge clk);
		check("off sampling", 0, sample_hold);
		// enable first: a start is only taken while the converter already runs
		bus(1'b1, c1, en);
		delay <= 8'd30;
		for (int f = 0; f < 8; f++) begin
			value <= 10'h1a5 + 10'(f * 77);
			bus(1'b1, c1, en | 32'(f) << 8 | 32'h2);
			repeat (2) @(posedge clk);
			check("sampling", 1, sample_hold);
			bus(1'b1, c1, en | 32'(f) << 8);
			bus(1'b0, c1, 32'h0);
			check("done on start", 0, q[0]);
			await(1, 80);
			bus(1'b0, c1, 32'h0);
			check("done set", 1, q[0]);
			bus(1'b0, bf, 32'h0);
			check("format", fmt(f, value), q);
		end
		bus(1'b1, c1, en | 32'h1);
		bus(1'b0, c1, 32'h0);
		check("done kept", 1, q[0]);
		bus(1'b1, c1, en);
		bus(1'b0, c1, 32'h0);
		check("done cleared", 0, q[0]);
	endtask

	task automatic t_trig();
		for (int s = 1; s < 7; s++) begin
			bus(1'b1, c1, en | 32'(s) << 5 | 32'h2);
			fire(1'b1);
			if (s < 4) begin
				await(0, 20);
				bus(1'b0, c1, 32'h0);
				check("sample bit", 0, q[1]);
				await(1, 60);
			end else begin
				repeat (20) begin
					@(posedge clk);
					check("reserved", 0, conv_start);
				end
			end
			external_irq_pin <= 1'b0;
			@(posedge clk);
		end
		bus(1'b1, c1, 32'h0);
	endtask

	task automatic t_auto();
		delay <= 8'd0;
		bus(1'b1, c2, 32'h408);
		bus(1'b1, c1, en | 32'h54);
		for (int i = 0; i < 3; i++) begin
			value <= 10'(i * 100 + 7);
			repeat (2) @(posedge clk);
			check("auto sampling", 1, sample_hold);
			fire(1'b0);
			await(1, 20);
			@(posedge clk);
			check("irq", 32'(i == 2), conv_irq);
			check("scan advance", 1, scan_advance);
		end
		repeat (2) @(posedge clk);
		check("stopped", 0, sample_hold);
		bus(1'b0, c1, 32'h0);
		check("auto start off", 0, q[2]);
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, bf + 5'(i), 32'h0);
			check("buffer word", 32'(i * 100 + 7), q);
		end
		bus(1'b1, c1, 32'h0);
	endtask

	task automatic t_split();
		bus(1'b1, c2, 32'h3);
		bus(1'b1, c1, en | 32'h44);
		for (int i = 0; i < 4; i++) begin
			value <= 10'(i + 40);
			repeat (2) @(posedge clk);
			check("mux b", 32'(i % 2), alternate_b_select);
			check("fill half", 32'(i % 2), buffer_fill_status);
			fire(1'b0);
			await(1, 20);
		end
		bus(1'b0, bf, 32'h0);
		check("low half", 32'd42, q);
		bus(1'b0, bf + 5'h08, 32'h0);
		check("high half", 32'd43, q);
		bus(1'b1, c1, 32'h0);
	endtask

	task automatic t_adc();
		int t;
		int last;
		int r;
		t = 0;
		last = 0;
		r = 0;
		bus(1'b1, c3, 32'h0501);
		bus(1'b1, c1, en);
		bus(1'b1, c1, en | 32'he2);
		for (int n = 1; n < 200 && conv_start !== 1'b1; n++) begin
			@(posedge clk);
			if (conversion_clock === 1'b1) begin
				if (t > 0)
					check("tick gap", 32'd4, 32'(n - last));
				last = n;
				t++;
			end
		end
		check("sample ticks", 1, 32'(t >= 4 && t <= 6));
		await(1, 60);
		// rc source: three rising edges of the oscillator give three ticks
		bus(1'b1, c3, 32'h8000);
		for (int k = 0; k < 56; k++) begin
			rc_osc <= k[3];
			@(posedge clk);
			r += int'(conversion_clock === 1'b1);
		end
		check("rc ticks", 3, 32'(r));
		bus(1'b1, c1, 32'h0);
	endtask

	task automatic t_idle();
		idle_mode <= 1'b1;
		repeat (6) @(posedge clk);
		bus(1'b1, c1, en | 32'h2000);
		bus(1'b1, c1, en | 32'h2002);
		repeat (6) @(posedge clk);
		check("idle halt", 0, sample_hold);
		bus(1'b1, c1, en);
		bus(1'b1, c1, en | 32'h2);
		repeat (6) @(posedge clk);
		check("idle run", 1, sample_hold);
		idle_mode <= 1'b0;
		bus(1'b1, c1, 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_sw();
		t_trig();
		t_auto();
		t_split();
		t_adc();
		t_idle();
		summarize();
	end
endmodule // tb

// ==== hdl/asc_pin_sync.sv ====
/*
 * Three-stage synchroniser for a pin from outside the clock domain, with
 * agreement filter and rising-edge pulse.
 * Assumes the pin is slow against clk; shorter pulses may be missed.
 */
module asc_pin_sync #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin,
	output logic      level,
	output logic      rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic filt;
		logic rise;
	} asc_sync_s;

	asc_sync_s q;
	asc_sync_s next_q;

	always_comb begin
		next_q = q;
		next_q.s1 = pin;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		// first stage feeds only the second; filter looks at stages two and three
		if (q.s2 == q.s3) begin
			next_q.filt = q.s3;
		end
		next_q.rise = next_q.filt & ~q.filt;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '{s1: INIT, s2: INIT, s3: INIT, filt: INIT, rise: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign level = q.filt;
	assign rise  = q.rise;
endmodule // asc_pin_sync

// ==== hdl/asc_pkg.sv ====
/*
 * Shared constants of the converter sequencer: register word indexes,
 * field positions, write masks, reset values and code points.
 * Assumes a single 100 MHz peripheral bus clock for all users.
 */
package asc_pkg;

	// register word indexes on the bus (word addressed)
	localparam logic [4:0]  IDX_CON1      = 5'h00;
	localparam logic [4:0]  IDX_CON2      = 5'h01;
	localparam logic [4:0]  IDX_CON3      = 5'h02;
	localparam logic [4:0]  IDX_BUF_BASE  = 5'h10;
	localparam logic [4:0]  IDX_BUF_MASK  = 5'h10;

	// control register one
	localparam int          CON1_ON       = 15;
	localparam int          CON1_STOP_IN_IDLE     = 13;
	localparam int          CON1_OUTPUT_FORMAT_LO  = 8;
	localparam int          CON1_TRIGGER_SOURCE_LO  = 5;
	localparam int          CON1_STOP_ON_FIRST_IRQ  = 4;
	localparam int          CON1_SAMPLE_AUTO_START     = 2;
	localparam int          CON1_SAMPLE_ACTIVE     = 1;
	localparam int          CON1_DONE     = 0;
	localparam logic [31:0] CON1_WMASK    = 32'h0000a7f4;

	// control register two
	localparam int          CON2_REFERENCE_CONFIG_LO  = 13;
	localparam int          CON2_OFFSET_CALIBRATION   = 12;
	localparam int          CON2_INPUT_SCAN_ENABLE    = 10;
	localparam int          CON2_BUFFER_FILL_STATUS     = 7;
	localparam int          CON2_SEQUENCES_PER_IRQ_LO  = 2;
	localparam int          CON2_BUFFER_SPLIT_MODE     = 1;
	localparam int          CON2_ALTERNATE_INPUT_MODE     = 0;
	localparam logic [31:0] CON2_WMASK    = 32'h0000f43f;

	// control register three: clock source, auto-sample time, divider
	localparam int          CON3_CONV_CLOCK_SOURCE     = 15;
	localparam int          CON3_AUTO_SAMPLE_TIME_LO  = 8;
	localparam int          CON3_CONV_CLOCK_DIVIDER_LO  = 0;
	localparam logic [31:0] CON3_WMASK    = 32'h00009fff;

	localparam logic [31:0] CON_RESET     = 32'h00000000;

	// trigger source codes; 100..110 are reserved
	localparam logic [2:0]  TRIG_SW       = 3'h0;
	localparam logic [2:0]  TRIG_PIN      = 3'h1;
	localparam logic [2:0]  TRIG_TIMER    = 3'h2;
	localparam logic [2:0]  TRIG_CHARGE   = 3'h3;
	localparam logic [2:0]  TRIG_AUTO     = 3'h7;

	// output format codes
	localparam logic [2:0]  FMT_INT16     = 3'h0;
	localparam logic [2:0]  FMT_FRAC16    = 3'h2;
	localparam logic [2:0]  FMT_SFRAC16   = 3'h3;
	localparam logic [2:0]  FMT_INT32     = 3'h4;
	localparam logic [2:0]  FMT_SINT32    = 3'h5;
	localparam logic [2:0]  FMT_SFRAC32   = 3'h7;

	localparam int          RESULT_W      = 10;
	localparam int          BUF_WORDS     = 16;

	typedef enum logic [1:0] {
		ST_HOLD    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b11
	} asc_state_e;

endpackage

// ==== hdl/asc_result_mem.sv ====
/*
 * Sixteen-word result store with one write port and a registered read port.
 * Assumes read address is held stable for the cycle before data is used.
 */
module asc_result_mem (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_addr,
	input  wire logic [31:0] wr_data,
	input  wire logic [3:0]  rd_addr,
	output logic      [31:0] rd_data
);
	typedef struct packed {
		logic [asc_pkg::BUF_WORDS-1:0][31:0] words;
		logic [31:0]                          rd_data;
	} asc_mem_s;

	asc_mem_s q;
	asc_mem_s next_q;

	always_comb begin
		next_q = q;
		if (wr_en) begin
			next_q.words[wr_addr] = wr_data;
		end
		next_q.rd_data = q.words[rd_addr];
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign rd_data = q.rd_data;
endmodule // asc_result_mem

// ==== hdl/asc_sequencer.sv ====
/*
 * Sample/convert sequencer of a 10-bit successive-approximation converter:
 * control registers on an Avalon-MM slave, trigger selection, conversion
 * clock divider, result formatting and the 16-word result store.
 * Assumes the analog front end, timer match and charge unit pulses are on clk;
 * idle, external trigger pin and rc oscillator are asynchronous.
 */
// Design decisions made here: the Avalon-MM register port and the address map.
// Notes on behaviour
// - converter runs only while the enable bit 15 is set.
// - with stop-in-idle set, idle mode halts the converter.
// - results formatted per output format code, justified, signed or zero filled.
// - trigger source picks what ends sampling; codes 100 to 110 reserved.
// - without auto-start, software writing one to sample bit starts sampling.
// - with software trigger, writing zero to sample bit starts a conversion.
// - other trigger sources clear the sample bit in hardware on the trigger.
// - with auto-start, sampling restarts right after each conversion completes.
// - done flag set on completion; software clears by zero; one ignored.
// - done flag clears automatically when a new conversion starts.
// - stop-on-first-interrupt clears auto-start when the interrupt is raised.
// - reference configuration field selects high and low references.
// - offset calibration ties both amplifier inputs to the low reference.
// - input scan bit lets the inputs advance across successive samples.
// - fill status shows which half is being filled in split mode.
// - interrupt after every N+1 sequences, N the sequences-per-interrupt field.
// - buffer split mode gives two alternating halves, else one 16-word buffer.
// - alternate mode uses setting A first, then B, A, B.
// - auto-convert samples for auto-sample-time conversion clock periods.
// - conversion clock period is bus period times 2 times (divider+1).
module asc_sequencer (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        idle_mode,
	input  wire logic        external_irq_pin,
	input  wire logic        timer_match,
	input  wire logic        charge_done,
	input  wire logic        rc_osc,
	input  wire logic        conv_done,
	input  wire logic [9:0]  conv_result,
	output logic             conversion_clock,
	output logic             sample_hold,
	output logic             conv_start,
	output logic [2:0]       reference_config,
	output logic             offset_calibration,
	output logic             input_scan_enable,
	output logic             scan_advance,
	output logic             alternate_b_select,
	output logic             buffer_fill_status,
	output logic             conv_irq
);
	typedef struct packed {
		logic [31:0]        con1;
		logic [31:0]        con2;
		logic [31:0]        con3;
		asc_pkg::asc_state_e state;
		logic [8:0]         div_cnt;
		logic               tad_tick;
		logic [4:0]         sample_active_cnt;
		logic [3:0]         seq_cnt;
		logic [3:0]         buf_idx;
		logic               use_b;
		logic               sampling;
		logic               conv_start;
		logic               scan_adv;
		logic               conv_irq;
		logic               bus_phase;
		logic               waitreq;
		logic [31:0]        rdata;
	} asc_ctl_s;

	asc_ctl_s    q;
	asc_ctl_s    next_q;
	logic        idle_sync;
	logic        ext_rise;
	logic        rc_rise;
	logic [31:0] mem_rd;
	logic        mem_we;
	logic [3:0]  mem_waddr;
	logic [31:0] mem_wdata;

	asc_pin_sync u_idle (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (idle_mode),
		.level (idle_sync),
		.rise  ()
	);

	asc_pin_sync u_ext (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (external_irq_pin),
		.level (),
		.rise  (ext_rise)
	);

	asc_pin_sync u_rc (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (rc_osc),
		.level (),
		.rise  (rc_rise)
	);

	asc_result_mem u_mem (
		.clk     (clk),
		.rst_b   (rst_b),
		.wr_en   (mem_we),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata),
		.rd_addr (avs_address[3:0]),
		.rd_data (mem_rd)
	);

	// signed codes are offset binary: flipping the msb gives two's complement
	function automatic logic [31:0] fmt_result(input logic [2:0] output_format, input logic [9:0] d);
		logic sgn;
		sgn = ~d[9];
		unique case (output_format)
			asc_pkg::FMT_FRAC16:  fmt_result = {16'h0000, d, 6'h00};
			asc_pkg::FMT_SFRAC16: fmt_result = {16'h0000, sgn, d[8:0], 6'h00};
			asc_pkg::FMT_SINT32:  fmt_result = {{22{sgn}}, sgn, d[8:0]};
			asc_pkg::FMT_SFRAC32: fmt_result = {sgn, d[8:0], 22'h000000};
			default:              fmt_result = {22'h000000, d};
		endcase
	endfunction

	logic        on;
	logic        active;
	logic        bus_req;
	logic        commit;
	logic        wr_con1;
	logic [31:0] be_mask;
	logic [2:0]  trigger_source;
	logic        sw_start;
	logic        sw_end;
	logic        trig_hit;
	logic        irq_event;
	logic        done_clr;

	always_comb begin
		on       = q.con1[asc_pkg::CON1_ON];
		// halted while disabled or idle with stop-in-idle set
		active   = on && !(q.con1[asc_pkg::CON1_STOP_IN_IDLE] && idle_sync);
		bus_req  = avs_read | avs_write;
		commit   = bus_req && !q.waitreq;
		wr_con1  = commit && avs_write && avs_address == asc_pkg::IDX_CON1
			&& avs_byteenable[0];
		be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		trigger_source     = q.con1[asc_pkg::CON1_TRIGGER_SOURCE_LO +: 3];
		sw_start = wr_con1 && avs_writedata[asc_pkg::CON1_SAMPLE_ACTIVE]
			&& !q.con1[asc_pkg::CON1_SAMPLE_AUTO_START];
		sw_end   = wr_con1 && !avs_writedata[asc_pkg::CON1_SAMPLE_ACTIVE];
		// only a write of zero clears; a one leaves the flag alone
		done_clr = wr_con1 && !avs_writedata[asc_pkg::CON1_DONE];
		unique case (trigger_source)
			asc_pkg::TRIG_SW:     trig_hit = sw_end;
			asc_pkg::TRIG_PIN:    trig_hit = ext_rise;
			asc_pkg::TRIG_TIMER:  trig_hit = timer_match;
			asc_pkg::TRIG_CHARGE: trig_hit = charge_done;
			asc_pkg::TRIG_AUTO:   trig_hit = q.tad_tick
				&& ({1'b0, q.sample_active_cnt} + 6'h01
				>= {1'b0, q.con3[asc_pkg::CON3_AUTO_SAMPLE_TIME_LO +: 5]});
			default:              trig_hit = 1'b0;
		endcase
		irq_event = q.state == asc_pkg::ST_CONVERT && conv_done && active
			&& q.seq_cnt == q.con2[asc_pkg::CON2_SEQUENCES_PER_IRQ_LO +: 4];
		mem_we    = q.state == asc_pkg::ST_CONVERT && conv_done && active;
		mem_waddr = q.con2[asc_pkg::CON2_BUFFER_SPLIT_MODE]
			? {q.con2[asc_pkg::CON2_BUFFER_FILL_STATUS], q.buf_idx[2:0]} : q.buf_idx;
		mem_wdata = fmt_result(q.con1[asc_pkg::CON1_OUTPUT_FORMAT_LO +: 3], conv_result);
	end

	always_comb begin
		next_q            = q;
		next_q.conv_start = 1'b0;
		next_q.scan_adv   = 1'b0;
		next_q.conv_irq   = 1'b0;
		next_q.tad_tick   = 1'b0;

		// conversion clock: 2*(divider+1) bus clocks, or the rc oscillator
		if (q.con3[asc_pkg::CON3_CONV_CLOCK_SOURCE]) begin
			next_q.tad_tick = rc_rise;
			next_q.div_cnt  = '0;
		end else if (q.div_cnt >= {q.con3[asc_pkg::CON3_CONV_CLOCK_DIVIDER_LO +: 8], 1'b1}) begin
			next_q.tad_tick = 1'b1;
			next_q.div_cnt  = '0;
		end else begin
			next_q.div_cnt  = q.div_cnt + 9'h001;
		end

		// bus: request seen, data fetched, then one cycle with waitrequest low
		if (bus_req && q.waitreq && !q.bus_phase) begin
			next_q.bus_phase = 1'b1;
		end else if (q.bus_phase) begin
			next_q.bus_phase = 1'b0;
			next_q.waitreq   = 1'b0;
			if ((avs_address & asc_pkg::IDX_BUF_MASK) == asc_pkg::IDX_BUF_BASE) begin
				next_q.rdata = mem_rd;
			end else if (avs_address == asc_pkg::IDX_CON1) begin
				next_q.rdata = q.con1;
			end else if (avs_address == asc_pkg::IDX_CON2) begin
				next_q.rdata = q.con2;
			end else if (avs_address == asc_pkg::IDX_CON3) begin
				next_q.rdata = q.con3;
			end else begin
				next_q.rdata = '0;
			end
		end else begin
			next_q.waitreq = 1'b1;
		end

		if (commit && avs_write) begin
			if (avs_address == asc_pkg::IDX_CON1) begin
				next_q.con1 = (q.con1 & ~(asc_pkg::CON1_WMASK & be_mask))
					| (avs_writedata & asc_pkg::CON1_WMASK & be_mask);
			end
			if (avs_address == asc_pkg::IDX_CON2) begin
				next_q.con2 = (q.con2 & ~(asc_pkg::CON2_WMASK & be_mask))
					| (avs_writedata & asc_pkg::CON2_WMASK & be_mask);
			end
			if (avs_address == asc_pkg::IDX_CON3) begin
				next_q.con3 = (q.con3 & ~(asc_pkg::CON3_WMASK & be_mask))
					| (avs_writedata & asc_pkg::CON3_WMASK & be_mask);
			end
		end
		if (done_clr) begin
			next_q.con1[asc_pkg::CON1_DONE] = 1'b0;
		end

		unique case (q.state)
			asc_pkg::ST_HOLD: begin
				if (active && (sw_start || next_q.con1[asc_pkg::CON1_SAMPLE_AUTO_START])) begin
					next_q.state    = asc_pkg::ST_SAMPLE;
					next_q.sample_active_cnt = '0;
				end
			end
			asc_pkg::ST_SAMPLE: begin
				if (!active) begin
					next_q.state = asc_pkg::ST_HOLD;
				end else if (trig_hit) begin
					next_q.state      = asc_pkg::ST_CONVERT;
					next_q.conv_start = 1'b1;
					next_q.con1[asc_pkg::CON1_DONE] = 1'b0;
				end else if (q.tad_tick) begin
					next_q.sample_active_cnt = q.sample_active_cnt + 5'h01;
				end
			end
			asc_pkg::ST_CONVERT: begin
				if (!active) begin
					next_q.state = asc_pkg::ST_HOLD;
				end else if (conv_done) begin
					// set after the software clear so a same-cycle event wins
					next_q.con1[asc_pkg::CON1_DONE] = 1'b1;
					next_q.scan_adv = q.con2[asc_pkg::CON2_INPUT_SCAN_ENABLE];
					next_q.use_b    = q.con2[asc_pkg::CON2_ALTERNATE_INPUT_MODE] & ~q.use_b;
					next_q.sample_active_cnt = '0;
					if (irq_event) begin
						next_q.conv_irq = 1'b1;
						next_q.seq_cnt  = '0;
						next_q.buf_idx  = '0;
						next_q.con2[asc_pkg::CON2_BUFFER_FILL_STATUS] = q.con2[asc_pkg::CON2_BUFFER_SPLIT_MODE]
							& ~q.con2[asc_pkg::CON2_BUFFER_FILL_STATUS];
						if (q.con1[asc_pkg::CON1_STOP_ON_FIRST_IRQ]) begin
							next_q.con1[asc_pkg::CON1_SAMPLE_AUTO_START] = 1'b0;
						end
					end else begin
						next_q.seq_cnt = q.seq_cnt + 4'h1;
						next_q.buf_idx = q.buf_idx + 4'h1;
					end
					next_q.state = next_q.con1[asc_pkg::CON1_SAMPLE_AUTO_START]
						? asc_pkg::ST_SAMPLE : asc_pkg::ST_HOLD;
				end
			end
			default: begin
				next_q.state = asc_pkg::ST_HOLD;
			end
		endcase

		// disabling restarts the buffer, the sequence count and the A/B order
		if (!on) begin
			next_q.seq_cnt = '0;
			next_q.buf_idx = '0;
			next_q.use_b   = 1'b0;
			next_q.con2[asc_pkg::CON2_BUFFER_FILL_STATUS] = 1'b0;
		end
		next_q.sampling = next_q.state == asc_pkg::ST_SAMPLE;
		// the sample bit reads back the sampling state
		next_q.con1[asc_pkg::CON1_SAMPLE_ACTIVE] = next_q.sampling;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q         <= '0;
			q.con1    <= asc_pkg::CON_RESET;
			q.con2    <= asc_pkg::CON_RESET;
			q.con3    <= asc_pkg::CON_RESET;
			q.state   <= asc_pkg::ST_HOLD;
			q.waitreq <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign avs_readdata       = q.rdata;
	assign avs_waitrequest    = q.waitreq;
	assign conversion_clock   = q.tad_tick;
	assign sample_hold        = q.sampling;
	assign conv_start         = q.conv_start;
	assign reference_config   = q.con2[asc_pkg::CON2_REFERENCE_CONFIG_LO +: 3];
	assign offset_calibration = q.con2[asc_pkg::CON2_OFFSET_CALIBRATION];
	assign input_scan_enable  = q.con2[asc_pkg::CON2_INPUT_SCAN_ENABLE];
	assign scan_advance       = q.scan_adv;
	assign alternate_b_select = q.use_b;
	assign buffer_fill_status = q.con2[asc_pkg::CON2_BUFFER_FILL_STATUS];
	assign conv_irq           = q.conv_irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	off_no_sample_a: assert property (!on |=> !sample_hold)
		else $error("sampling while disabled");
	idle_halt_a: assert property (on && q.con1[asc_pkg::CON1_STOP_IN_IDLE] && idle_sync
		|=> !sample_hold && !conv_start)
		else $error("converter ran in idle");
	format_a: assert property (mem_we && q.con1[asc_pkg::CON1_OUTPUT_FORMAT_LO +: 3]
		== asc_pkg::FMT_FRAC16 |-> mem_wdata == {16'h0000, conv_result, 6'h00})
		else $error("fractional format wrong");
	reserved_trig_a: assert property (trigger_source inside {3'h4, 3'h5, 3'h6}
		|=> !conv_start)
		else $error("reserved trigger started conversion");
	sw_start_a: assert property (sw_start && active && q.state == asc_pkg::ST_HOLD
		|=> sample_hold ##0 q.con1[asc_pkg::CON1_SAMPLE_ACTIVE])
		else $error("software start ignored");
	sw_end_a: assert property (sw_end && trigger_source == asc_pkg::TRIG_SW && active
		&& q.state == asc_pkg::ST_SAMPLE |=> conv_start && !sample_hold)
		else $error("software end ignored");
	pin_trig_a: assert property (ext_rise && trigger_source == asc_pkg::TRIG_PIN && active
		&& q.state == asc_pkg::ST_SAMPLE |=> conv_start
		&& !q.con1[asc_pkg::CON1_SAMPLE_ACTIVE])
		else $error("pin trigger did not end sampling");
	auto_restart_a: assert property (mem_we && q.con1[asc_pkg::CON1_SAMPLE_AUTO_START]
		&& !q.con1[asc_pkg::CON1_STOP_ON_FIRST_IRQ] |=> sample_hold)
		else $error("auto-start did not resume sampling");
	done_set_a: assert property (mem_we |=> q.con1[asc_pkg::CON1_DONE]
		&& !conv_start)
		else $error("done flag not set");
	done_clr_a: assert property (conv_start |-> !q.con1[asc_pkg::CON1_DONE])
		else $error("done flag not cleared at start");
	stop_first_a: assert property (irq_event && q.con1[asc_pkg::CON1_STOP_ON_FIRST_IRQ]
		|=> conv_irq && !q.con1[asc_pkg::CON1_SAMPLE_AUTO_START] ##1 !conv_start)
		else $error("auto-start not cleared at interrupt");
	irq_count_a: assert property (conv_irq |-> $past(q.seq_cnt)
		== q.con2[asc_pkg::CON2_SEQUENCES_PER_IRQ_LO +: 4] && q.buf_idx == 4'h0)
		else $error("interrupt at wrong sequence count");
	bus_answer_a: assert property (bus_req && q.waitreq && !q.bus_phase
		|=> q.waitreq ##1 !avs_waitrequest)
		else $error("bus answer late");
endmodule // asc_sequencer
